//--- pkg/audio_link_pkg.sv
package audio_link_pkg;
  localparam int CLK_MHZ        = 100;
  localparam int UNMUTE_TIME_US = 10;
  localparam int UNMUTE_CYC     = UNMUTE_TIME_US * CLK_MHZ;
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] PAD_OFS  = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  localparam logic [3:0] CFG_OFS  = 4'hC;
  localparam int CTRL_COMP_BIT = 0;
  localparam int CTRL_CLKM_BIT = 1;
  localparam int CTRL_WW_LSB   = 2;
  localparam logic [31:0] CTRL_RST = 32'h00000040;
  localparam logic [31:0] PAD_RST  = 32'h00000000;
  localparam int PAD_OUT_LSB  = 0;
  localparam int PAD_DIR_LSB  = 4;
  localparam int PAD_PULL_LSB = 8;
  localparam int CFG_ROLE_BIT   = 0;
  localparam int CFG_STEREO_BIT = 1;
  localparam int CFG_D0_LSB     = 2;
  localparam int CFG_D1_LSB     = 4;
  localparam int CFG_DEV_BIT    = 6;
  localparam logic [1:0] DIR_UNUSED = 2'h0;
  localparam logic [1:0] DIR_IN     = 2'h1;
  localparam logic [1:0] DIR_OUT    = 2'h2;
  localparam logic [1:0] PULL_UP    = 2'h1;
  localparam logic [1:0] PULL_DOWN  = 2'h2;
  localparam logic [4:0] WW_MIN   = 5'h10;
  localparam logic [4:0] WW_MAX   = 5'h18;
  localparam logic [4:0] SAMPLE_W = 5'h10;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CODEC = 4'b0010,
    ST_JOIN  = 4'b0100,
    ST_RUN   = 4'b1000
  } role_st_e;
endpackage : audio_link_pkg

//--- verilog/wireless_audio_link_port.sv
`timescale 1ns/1ns
module wireless_audio_link_port import audio_link_pkg::*; #(
  parameter int MCLK_HALF = 4,
  parameter int BCLK_HALF = 8,
  parameter int NPAD      = 4,
  parameter int NSEC      = 4
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [3:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [3:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              cfg_loaded,
  input  wire logic [7:0]        cfg_image,
  output logic                   codec_cfg_go,
  input  wire logic              codec_cfg_done,
  input  wire logic              net_formed,
  input  wire logic [1:0]        peer_cnt,
  input  wire logic              link_good,
  output logic                   net_search,
  output logic                   net_create,
  output logic                   ref_clk_drive,
  output logic                   ref_clk_regen,
  output logic                   side_chan_en,
  output logic                   afh_en,
  output logic                   compress_en,
  input  wire logic              pkt_done,
  input  wire logic [NSEC-1:0]   sec_err,
  output logic                   retx_req,
  output logic [NSEC-1:0]        retx_mask,
  input  wire logic [15:0]       rx_left,
  input  wire logic [15:0]       rx_right,
  input  wire logic              rx_valid,
  output logic [15:0]            tx_left,
  output logic [15:0]            tx_right,
  output logic                   tx_valid,
  output logic                   mclk_o,
  input  wire logic              bclk_i,
  output logic                   bclk_o,
  output logic                   bclk_oe_n,
  input  wire logic              wclk_i,
  output logic                   wclk_o,
  output logic                   wclk_oe_n,
  input  wire logic [1:0]        audio_data_i,
  output logic [1:0]             audio_data_o,
  output logic [1:0]             audio_data_oe_n,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_rd_data,
  output logic                   miso_o,
  output logic [NPAD-1:0]        gio_o,
  output logic [NPAD-1:0]        gio_oe_n,
  output logic [NPAD-1:0]        gio_pu,
  output logic [NPAD-1:0]        gio_pd
);

  logic [31:0]     ctrl_ff, pad_ff, rdata_ff;
  logic [7:0]      cfg_ff;
  logic [3:0]      awaddr_ff;
  logic [31:0]     wdata_ff;
  logic [3:0]      wstrb_ff;
  logic            aw_hold_ff, w_hold_ff, bvalid_ff, rvalid_ff;
  logic [1:0]      bresp_ff, rresp_ff;
  role_st_e        st_ff, nxt_st;
  logic            go_ff, mute_ff, retx_ff;
  logic [NSEC-1:0] retx_mask_ff;
  logic [15:0]     good_cnt_ff;
  logic [15:0]     play_l_ff, play_r_ff, tx_l_ff, tx_r_ff, rx_sh_ff, tx_sh_ff;
  logic            tx_valid_ff;
  logic [7:0]      mdiv_ff, bdiv_ff;
  logic            mclk_ff, bclk_ff, ws_o_ff;
  logic [4:0]      wcnt_ff, bitcnt_ff;
  logic [2:0]      bclk_s_ff;
  logic [1:0]      wclk_s_ff, cs_s_ff;
  logic [1:0]      din_s0_ff, din_s1_ff;
  logic            ws_r_ff, ws_q_ff, ser_ff, miso_ff;

  // register bus decode
  wire         aw_ok   = aw_hold_ff | (awvalid & awready);
  wire         w_ok    = w_hold_ff | (wvalid & wready);
  wire  [3:0]  wa      = aw_hold_ff ? awaddr_ff : awaddr;
  wire  [31:0] wd      = w_hold_ff ? wdata_ff : wdata;
  wire  [3:0]  ws      = w_hold_ff ? wstrb_ff : wstrb;
  wire         do_wr   = aw_ok & w_ok & ~bvalid_ff;
  wire  [31:0] wmask   = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
  wire         wr_ctrl = do_wr & (wa == CTRL_OFS);
  wire         wr_pad  = do_wr & (wa == PAD_OFS);
  wire         wa_map  = (wa == CTRL_OFS) | (wa == PAD_OFS);
  wire  [31:0] stat_w  = {16'h0000, 4'h0, st_ff, mute_ff, net_formed, peer_cnt,
                          cfg_ff[CFG_ROLE_BIT], ws_r_ff, 2'h0};
  wire  [31:0] rd_mux  = (araddr == CTRL_OFS) ? ctrl_ff :
                         (araddr == PAD_OFS)  ? pad_ff :
                         (araddr == STAT_OFS) ? stat_w :
                         (araddr == CFG_OFS)  ? {24'h000000, cfg_ff} : 32'h00000000;
  wire         ra_map  = (araddr == CTRL_OFS) | (araddr == PAD_OFS) |
                         (araddr == STAT_OFS) | (araddr == CFG_OFS);

  assign awready = ~aw_hold_ff & ~bvalid_ff;
  assign wready  = ~w_hold_ff & ~bvalid_ff;
  assign arready = ~rvalid_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign rvalid  = rvalid_ff;
  assign rresp   = rresp_ff;
  assign rdata   = rdata_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OK;
    end else begin
      if (awvalid & awready) awaddr_ff <= awaddr;
      if (wvalid & wready) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      aw_hold_ff <= aw_ok & ~do_wr;
      w_hold_ff  <= w_ok & ~do_wr;
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= wa_map ? RESP_OK : RESP_ERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= RESP_OK;
    end else if (arvalid & arready) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_mux;
      rresp_ff  <= ra_map ? RESP_OK : RESP_ERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RST;
      pad_ff  <= PAD_RST;
    end else begin
      if (wr_ctrl) ctrl_ff <= (ctrl_ff & ~wmask) | (wd & wmask);
      if (wr_pad) pad_ff <= (pad_ff & ~wmask) | (wd & wmask);
    end
  end

  // pads: direction and termination per pad
  for (genvar i = 0; i < NPAD; i++) begin : g_pad
    wire [1:0] pull = pad_ff[PAD_PULL_LSB + 2*i +: 2];
    assign gio_o[i]    = pad_ff[PAD_OUT_LSB + i];
    assign gio_oe_n[i] = ~pad_ff[PAD_DIR_LSB + i];
    assign gio_pu[i]   = (pull == PULL_UP);
    assign gio_pd[i]   = (pull == PULL_DOWN);
  end

  // serial data-out pin sharing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_s_ff <= 2'h3;
      miso_ff <= 1'b0;
    end else begin
      cs_s_ff <= {cs_s_ff[0], spi_cs_n};
      miso_ff <= cs_s_ff[1] ? gio_o[0] : spi_rd_data;
    end
  end
  assign miso_o = miso_ff;

  // role sequencing
  wire is_master = cfg_ff[CFG_ROLE_BIT];
  wire formed_ok = net_formed & (peer_cnt != 2'h0) & (peer_cnt != 2'h3);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_IDLE:  if (cfg_loaded) nxt_st = ST_CODEC;
      ST_CODEC: if (!cfg_ff[CFG_DEV_BIT] || codec_cfg_done) nxt_st = ST_JOIN;
      ST_JOIN:  if (formed_ok) nxt_st = ST_RUN;
      ST_RUN:   if (!formed_ok) nxt_st = ST_JOIN;
      default:  nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff  <= ST_IDLE;
      cfg_ff <= 8'h00;
      go_ff  <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      if (st_ff == ST_IDLE && cfg_loaded) cfg_ff <= cfg_image;
      go_ff <= (st_ff == ST_IDLE) & cfg_loaded & cfg_image[CFG_DEV_BIT];
    end
  end

  assign codec_cfg_go  = go_ff;
  assign net_search    = (st_ff == ST_JOIN) & ~is_master;
  assign net_create    = (st_ff == ST_JOIN) & is_master;
  assign ref_clk_drive = is_master & (st_ff != ST_IDLE);
  assign ref_clk_regen = ~is_master & (st_ff == ST_RUN);
  assign side_chan_en  = (st_ff == ST_RUN);
  assign afh_en        = (st_ff == ST_JOIN) | (st_ff == ST_RUN);
  assign compress_en   = ctrl_ff[CTRL_COMP_BIT];

  // mute and section retransmission
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mute_ff      <= 1'b1;
      good_cnt_ff  <= 16'h0000;
      retx_ff      <= 1'b0;
      retx_mask_ff <= '0;
    end else begin
      if (!link_good || st_ff != ST_RUN) begin
        mute_ff     <= 1'b1;
        good_cnt_ff <= 16'h0000;
      end else if (good_cnt_ff == 16'(UNMUTE_CYC - 1)) begin
        mute_ff <= 1'b0;
      end else begin
        good_cnt_ff <= good_cnt_ff + 16'h0001;
      end
      retx_ff <= pkt_done & (|sec_err);
      if (pkt_done) retx_mask_ff <= sec_err;
    end
  end
  assign retx_req  = retx_ff;
  assign retx_mask = retx_mask_ff;

  // buffered received samples, zeroed while muted
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      play_l_ff <= 16'h0000;
      play_r_ff <= 16'h0000;
    end else if (mute_ff) begin
      play_l_ff <= 16'h0000;
      play_r_ff <= 16'h0000;
    end else if (rx_valid) begin
      play_l_ff <= rx_left;
      play_r_ff <= cfg_ff[CFG_STEREO_BIT] ? rx_right : rx_left;
    end
  end

  // clock generation and sampling
  wire       clk_master = is_master & ctrl_ff[CTRL_CLKM_BIT];
  wire [4:0] ww_reg     = ctrl_ff[CTRL_WW_LSB +: 5];
  wire [4:0] ww         = (ww_reg < WW_MIN) ? WW_MIN : (ww_reg > WW_MAX) ? WW_MAX : ww_reg;
  wire       bdiv_end   = (bdiv_ff == 8'(BCLK_HALF - 1));
  wire       m_rise     = clk_master & bdiv_end & ~bclk_ff;
  wire       m_fall     = clk_master & bdiv_end & bclk_ff;
  wire       s_rise     = ~clk_master & bclk_s_ff[1] & ~bclk_s_ff[2];
  wire       s_fall     = ~clk_master & ~bclk_s_ff[1] & bclk_s_ff[2];
  wire       bit_rise   = m_rise | s_rise;
  wire       bit_fall   = m_fall | s_fall;
  wire       ws_now     = clk_master ? ws_o_ff : wclk_s_ff[1];
  wire [1:0] d0_dir     = cfg_ff[CFG_D0_LSB +: 2];
  wire [1:0] d1_dir     = cfg_ff[CFG_D1_LSB +: 2];
  wire       din        = (d0_dir == DIR_IN) ? din_s1_ff[0] :
                          (d1_dir == DIR_IN) ? din_s1_ff[1] : 1'b0;
  wire       word_edge  = bit_fall & (ws_r_ff != ws_q_ff);
  wire [15:0] samp      = ws_r_ff ? play_r_ff : play_l_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mdiv_ff <= 8'h00;
      mclk_ff <= 1'b0;
    end else if (mdiv_ff == 8'(MCLK_HALF - 1)) begin
      mdiv_ff <= 8'h00;
      mclk_ff <= ~mclk_ff;
    end else begin
      mdiv_ff <= mdiv_ff + 8'h01;
    end
  end
  assign mclk_o = mclk_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bdiv_ff <= 8'h00;
      bclk_ff <= 1'b0;
      ws_o_ff <= 1'b0;
      wcnt_ff <= 5'h00;
    end else if (!clk_master || bdiv_end) begin
      bdiv_ff <= 8'h00;
      bclk_ff <= clk_master & ~bclk_ff;
      if (m_fall) begin
        wcnt_ff <= (wcnt_ff == ww - 5'h01) ? 5'h00 : wcnt_ff + 5'h01;
        if (wcnt_ff == ww - 5'h01) ws_o_ff <= ~ws_o_ff;
      end
    end else begin
      bdiv_ff <= bdiv_ff + 8'h01;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bclk_s_ff <= 3'h0;
      wclk_s_ff <= 2'h0;
      din_s0_ff <= 2'h0;
      din_s1_ff <= 2'h0;
    end else begin
      bclk_s_ff <= {bclk_s_ff[1:0], bclk_i};
      wclk_s_ff <= {wclk_s_ff[0], wclk_i};
      din_s0_ff <= audio_data_i;
      din_s1_ff <= din_s0_ff;
    end
  end

  // serial audio: sample on rise, shift out on fall
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ws_r_ff     <= 1'b0;
      ws_q_ff     <= 1'b0;
      bitcnt_ff   <= 5'h1F;
      rx_sh_ff    <= 16'h0000;
      tx_sh_ff    <= 16'h0000;
      ser_ff      <= 1'b0;
      tx_l_ff     <= 16'h0000;
      tx_r_ff     <= 16'h0000;
      tx_valid_ff <= 1'b0;
    end else begin
      tx_valid_ff <= 1'b0;
      if (bit_rise) begin
        ws_r_ff <= ws_now;
        if (bitcnt_ff < SAMPLE_W) rx_sh_ff <= {rx_sh_ff[14:0], din};
        if (bitcnt_ff != 5'h1F) bitcnt_ff <= bitcnt_ff + 5'h01;
      end
      if (bit_fall) begin
        ws_q_ff <= ws_r_ff;
      end
      if (word_edge) begin
        bitcnt_ff <= 5'h00;
        tx_sh_ff  <= {samp[14:0], 1'b0};
        ser_ff    <= samp[15];
        if (ws_q_ff) begin
          tx_r_ff     <= cfg_ff[CFG_STEREO_BIT] ? rx_sh_ff : tx_l_ff;
          tx_valid_ff <= 1'b1;
        end else begin
          tx_l_ff <= rx_sh_ff;
        end
      end else if (bit_fall) begin
        tx_sh_ff <= {tx_sh_ff[14:0], 1'b0};
        ser_ff   <= tx_sh_ff[15];
      end
    end
  end

  assign tx_left         = tx_l_ff;
  assign tx_right        = tx_r_ff;
  assign tx_valid        = tx_valid_ff;
  assign bclk_o          = bclk_ff;
  assign wclk_o          = ws_o_ff;
  assign bclk_oe_n       = ~clk_master;
  assign wclk_oe_n       = ~clk_master;
  assign audio_data_o    = {2{ser_ff}};
  assign audio_data_oe_n = {d1_dir != DIR_OUT, d0_dir != DIR_OUT};

  a_miso_share: assert property (@(posedge aclk) disable iff (!aresetn)
    cs_s_ff[1] |=> miso_o == $past(gio_o[0])) else $error("miso not general io");
  a_search_role: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == ST_CODEC && codec_cfg_done && !is_master) |=> net_search && !net_create)
    else $error("slave not searching");
  a_create_role: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == ST_CODEC && !cfg_ff[CFG_DEV_BIT] && is_master) |=> net_create && !net_search)
    else $error("master not creating");
  a_stream_start: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == ST_JOIN && formed_ok) |=> st_ff == ST_RUN && side_chan_en)
    else $error("stream did not start");
  a_codec_cfg: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == ST_IDLE && cfg_loaded && cfg_image[CFG_DEV_BIT]) |=> codec_cfg_go
    ##1 !codec_cfg_go) else $error("codec config pulse wrong");
  a_peer_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    (st_ff == ST_RUN) |-> $past(net_formed) &&
    ($past(peer_cnt) == 2'h1 || $past(peer_cnt) == 2'h2))
    else $error("bad peer count in run");
  sequence s_bad_pkt;
    pkt_done && (|sec_err);
  endsequence
  a_retx_sect: assert property (@(posedge aclk) disable iff (!aresetn)
    s_bad_pkt |=> retx_req && retx_mask == $past(sec_err) ##1 !retx_req)
    else $error("retransmit request wrong");
  a_mute_poor: assert property (@(posedge aclk) disable iff (!aresetn)
    !link_good |=> mute_ff ##1 play_l_ff == 16'h0000) else $error("not muted");
  a_unmute_wait: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(mute_ff) |-> good_cnt_ff == 16'(UNMUTE_CYC - 1)) else $error("early unmute");
  a_dir_unused: assert property (@(posedge aclk) disable iff (!aresetn)
    (d0_dir != DIR_OUT) |-> audio_data_oe_n[0]) else $error("unused pin driven");
  a_msb_first: assert property (@(posedge aclk) disable iff (!aresetn)
    word_edge |=> ser_ff == $past(samp[15]) && bitcnt_ff == 5'h00)
    else $error("msb not after word edge");

endmodule : wireless_audio_link_port

//--- verif/codec_model.sv
`timescale 1ns/1ns
module codec_model (
  input  wire logic        aclk,
  input  wire logic        run,
  input  wire logic [4:0]  ww,
  input  wire logic [15:0] left,
  input  wire logic [15:0] right,
  input  wire logic        cfg_go,
  output logic             cfg_done,
  output logic             bclk,
  output logic             wclk,
  output logic             sdata
);
  int k;
  int j;
  // clock master toward the port; bit clock stands still while stopped
  initial begin
    bclk = 1'b0;
    wclk = 1'b0;
    sdata = 1'b0;
    k = 0;
    forever begin
      if (!run) begin
        sdata = ~sdata;
        @(posedge run);
      end
      #80 bclk = 1'b1;
      #80 bclk = 1'b0;
      k = (k + 1) % (2 * ww);
      j = (k + 2 * ww - 1) % (2 * ww);
      wclk = (k >= ww);
      // msb one bit clock after the word clock edge, padding below bit 16
      sdata = ((j % ww) >= 16) ? 1'b0 : ((j < ww) ? left[15 - j] : right[15 - j + ww]);
    end
  end
  // slow answer to the power-up configuration request
  initial begin
    cfg_done = 1'b0;
    forever begin
      @(posedge aclk);
      while (cfg_go !== 1'b1) @(posedge aclk);
      repeat (20) @(posedge aclk);
      cfg_done <= 1'b1;
      @(posedge aclk);
      cfg_done <= 1'b0;
    end
  end
endmodule : codec_model

//--- verif/wireless_audio_link_port_tb_top.sv
`timescale 1ns/1ns
module wireless_audio_link_port_tb_top;
  import audio_link_pkg::*;
  typedef struct packed {
    logic        wr;
    logic [3:0]  a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
    logic [1:0]  r;
  } row_s;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, cfg_loaded;
  logic        codec_cfg_done, net_formed, link_good, pkt_done, rx_valid, spi_cs_n;
  logic        spi_rd_data, awready, wready, bvalid, arready, rvalid, codec_cfg_go;
  logic        net_search, net_create, ref_clk_drive, ref_clk_regen, side_chan_en, afh_en;
  logic        compress_en, retx_req, tx_valid, mclk_o, bclk_o, bclk_oe_n, wclk_o;
  logic        wclk_oe_n, miso_o, cbclk, cwclk, csd, crun, go_seen, p;
  logic [1:0]  bresp, rresp, peer_cnt, audio_data_o, audio_data_oe_n, r;
  logic [3:0]  awaddr, araddr, wstrb, sec_err, retx_mask, gio_o, gio_oe_n, gio_pu, gio_pd;
  logic [4:0]  cww, ww;
  logic [7:0]  cfg_image;
  logic [15:0] rx_left, rx_right, tx_left, tx_right, cl, cr;
  logic [31:0] wdata, rdata, d;
  int          miscompares, total_checks, i, n, c;
  wire logic       bclk_i = bclk_oe_n ? cbclk : bclk_o;
  wire logic       wclk_i = wclk_oe_n ? cwclk : wclk_o;
  wire logic [1:0] audio_data_i = {audio_data_oe_n[1] ? csd : audio_data_o[1],
                                   audio_data_oe_n[0] ? csd : audio_data_o[0]};
  row_s rows[10] = '{
    '{1'b0, CTRL_OFS, 32'h0, 32'hFFFFFFFF, CTRL_RST, RESP_OK},
    '{1'b0, PAD_OFS, 32'h0, 32'hFFFFFFFF, PAD_RST, RESP_OK},
    '{1'b0, STAT_OFS, 32'h0, 32'h00000F00, 32'h00000100, RESP_OK},
    '{1'b1, PAD_OFS, 32'h00006435, 32'h0, 32'h0, RESP_OK},
    '{1'b0, PAD_OFS, 32'h0, 32'hFFFFFFFF, 32'h00006435, RESP_OK},
    '{1'b1, CTRL_OFS, 32'h00000041, 32'h0, 32'h0, RESP_OK},
    '{1'b1, STAT_OFS, 32'h00000001, 32'h0, 32'h0, RESP_ERR},
    '{1'b1, CFG_OFS, 32'h00000001, 32'h0, 32'h0, RESP_ERR},
    '{1'b1, 4'h2, 32'h00000001, 32'h0, 32'h0, RESP_ERR},
    '{1'b0, 4'h2, 32'h0, 32'hFFFFFFFF, 32'h0, RESP_ERR}};

  wireless_audio_link_port i_wireless_audio_link_port (.*);

  codec_model i_codec_model (
    .aclk(aclk), .run(crun), .ww(cww), .left(cl), .right(cr), .cfg_go(codec_cfg_go),
    .cfg_done(codec_cfg_done), .bclk(cbclk), .wclk(cwclk), .sdata(csd)
  );

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  always @(posedge aclk) go_seen <= aresetn ? (go_seen | (codec_cfg_go === 1'b1)) : 1'b0;

  task automatic finish_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, k, lim);
      miscompares++;
      finish_test();
    end
  endtask : tmo

  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask : cyc

  task automatic axw(input logic [3:0] a, input logic [31:0] v);
    int k;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    tmo(k, 50);
    r = bresp;
  endtask : axw

  task automatic axr(input logic [3:0] a);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    tmo(k, 50);
    d = rdata;
    r = rresp;
  endtask : axr

  task automatic rdc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
    axr(a);
    chk(d & m, e);
  endtask : rdc

  task automatic bring();
    aresetn <= 1'b0;
    {cfg_loaded, net_formed, link_good} <= '0;
    cyc(3);
    aresetn <= 1'b1;
  endtask : bring

  initial begin
    {aresetn, awvalid, wvalid, arvalid, cfg_loaded, net_formed, link_good} = '0;
    {pkt_done, rx_valid, spi_rd_data, crun, miscompares, total_checks} = '0;
    {awaddr, araddr, wdata, cfg_image, peer_cnt, sec_err, rx_left, rx_right, cl, cr} = '0;
    {bready, rready, spi_cs_n, wstrb, cww} = {3'b111, 4'hF, WW_MIN};
    bring();
    for (i = 0; i < 10; i++) begin
      if (rows[i].wr) axw(rows[i].a, rows[i].d);
      else rdc(rows[i].a, rows[i].m, rows[i].e);
      chk(r, rows[i].r);
    end
    chk({gio_o, gio_oe_n, gio_pu, gio_pd}, 16'h5CA4);
    chk(compress_en, 1'b1);
    axw(CTRL_OFS, CTRL_RST);
    cyc(1);
    chk(compress_en, 1'b0);
    spi_cs_n <= 1'b0;
    cyc(6);
    chk(miso_o, 1'b0);
    spi_cs_n <= 1'b1;
    cyc(6);
    chk(miso_o, 1'b1);
    // network slave, supported device, line 0 in, line 1 out
    cfg_image <= 8'h66;
    cfg_loaded <= 1'b1;
    for (n = 0; n < 200 && net_search !== 1'b1; n++) @(posedge aclk);
    tmo(n, 200);
    chk(go_seen, 1'b1);
    chk({net_search, net_create, ref_clk_regen, ref_clk_drive}, 4'h8);
    chk(audio_data_oe_n, 2'b01);
    rdc(CFG_OFS, 32'h000000FF, 32'h00000066);
    peer_cnt <= 2'h3;
    net_formed <= 1'b1;
    cyc(20);
    rdc(STAT_OFS, 32'h00000F00, 32'h00000400);
    peer_cnt <= 2'h1;
    cyc(5);
    rdc(STAT_OFS, 32'h00000F00, 32'h00000800);
    chk({side_chan_en, afh_en, ref_clk_regen}, 3'b111);
    link_good <= 1'b1;
    cyc(900);
    rdc(STAT_OFS, 32'h00000080, 32'h00000080);
    cyc(200);
    rdc(STAT_OFS, 32'h00000080, 32'h0);
    crun <= 1'b1;
    for (i = 0; i < 2; i++) begin
      ww = i ? WW_MAX : WW_MIN;
      axw(CTRL_OFS, {25'h0, ww, 2'b00});
      cww <= ww;
      cl <= i ? 16'h8001 : 16'hA5C3;
      cr <= i ? 16'h7FFE : 16'h3C5A;
      c = 0;
      for (n = 0; n < 6000 && c < 3; n++) begin
        @(posedge aclk);
        if (tx_valid === 1'b1) c++;
      end
      tmo(n, 6000);
      chk({tx_left, tx_right}, {cl, cr});
    end
    chk({bclk_oe_n, wclk_oe_n}, 2'b11);
    p = mclk_o;
    c = 0;
    for (n = 0; n < 80; n++) begin
      @(posedge aclk);
      c += int'(mclk_o & ~p);
      p = mclk_o;
    end
    chk(c, 10);
    for (i = 0; i < 2; i++) begin
      pkt_done <= 1'b1;
      sec_err <= i ? 4'h0 : 4'h5;
      @(posedge aclk);
      pkt_done <= 1'b0;
      @(posedge aclk);
      chk({retx_req, retx_mask}, i ? 5'h00 : 5'h15);
      @(posedge aclk);
      chk(retx_req, 1'b0);
    end
    link_good <= 1'b0;
    cyc(5);
    rdc(STAT_OFS, 32'h00000080, 32'h00000080);
    // network master, unsupported device
    crun <= 1'b0;
    bring();
    cfg_image <= 8'h27;
    cfg_loaded <= 1'b1;
    for (n = 0; n < 200 && net_create !== 1'b1; n++) @(posedge aclk);
    tmo(n, 200);
    chk(go_seen, 1'b0);
    chk({net_search, net_create, ref_clk_regen, ref_clk_drive}, 4'h5);
    axw(CTRL_OFS, 32'h00000042);
    cyc(2);
    chk({bclk_oe_n, wclk_oe_n}, 2'b00);
    // own clocks: bit clock every 16 cycles, word clock every 32 bit clocks
    r = {wclk_o, bclk_o};
    c = 0;
    i = 0;
    for (n = 0; n < 1024; n++) begin
      @(posedge aclk);
      c += int'(bclk_o & ~r[0]);
      i += int'(wclk_o & ~r[1]);
      r = {wclk_o, bclk_o};
    end
    chk(c, 64);
    chk(i, 2);
    finish_test();
  end
endmodule : wireless_audio_link_port_tb_top
